// *** common/serial_port_defines.svh ***
// named constants for the serial slave port of the clock/ram device
// assumes inclusion by bare name from the design files
`ifndef SERIAL_PORT_DEFINES_SVH
`define SERIAL_PORT_DEFINES_SVH
`define SLAVE_ADDR_7      7'h68
`define ADDR_RAM_LAST     15'h7FEF
`define ADDR_RSV_FIRST    15'h7FF0
`define ADDR_RSV_LAST     15'h7FF6
`define ADDR_SUBSEC       15'h7FF7
`define ADDR_CTRL         15'h7FF8
`define ADDR_SECONDS      15'h7FF9
`define ADDR_MINUTES      15'h7FFA
`define ADDR_HOURS        15'h7FFB
`define ADDR_TAMPER_DAY   15'h7FFC
`define ADDR_DATE         15'h7FFD
`define ADDR_MONTH        15'h7FFE
`define ADDR_YEAR         15'h7FFF
`define CLK_HZ            50000000
`define RECOVERY_DELAY_US 200
`define BIT_LAST          3'h7
`define RTC_REGS          9
`endif

// *** common/serial_port_pkg.sv ***
// types shared by the serial slave port
// assumes no other package
package serial_port_pkg;
  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_DEV_ADDR,
    ST_ADDR_HI,
    ST_ADDR_LO,
    ST_WRITE,
    ST_READ,
    ST_IGNORE
  } port_state_t;
  typedef logic [14:0] byte_addr_t;
  typedef logic [7:0]  data_byte_t;
endpackage

// *** logic/rtc_sram_serial_slave_port.sv ***
// serial two-wire slave port with ram and timekeeping register storage
// assumes bus pins are asynchronous; power-fail flag from an analog sense
`timescale 1ns/100ps
`include "serial_port_defines.svh"

module rtc_sram_serial_slave_port
  import serial_port_pkg::*;
#(
  parameter int RECOVERY_CYCLES =
    (`RECOVERY_DELAY_US * (`CLK_HZ / 1000000))
)
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset,
  // supply sense, high while below threshold
  input  wire logic                    power_fail,
  // bus pins
  input  wire logic                    scl_in,
  input  wire logic                    sda_in,
  output logic                         sda_out,
  output logic                         sda_oe,
  // status
  output logic                         write_protect,
  output logic                         bus_busy,
  output serial_port_pkg::byte_addr_t  addr_pointer
);
  import serial_port_pkg::*;

  localparam int RAM_WORDS = 32768;

  // --------------------------------------------------------------
  // synchronisers
  // --------------------------------------------------------------
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic [1:0] pf_sync_q;
  logic       scl_q;
  logic       sda_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      pf_sync_q  <= 2'h3;
      scl_q      <= 1'h1;
      sda_q      <= 1'h1;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      pf_sync_q  <= {pf_sync_q[0], power_fail};
      scl_q      <= scl_sync_q[1];
      sda_q      <= sda_sync_q[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic pf_s;
  assign scl_s = scl_sync_q[1];
  assign sda_s = sda_sync_q[1];
  assign pf_s  = pf_sync_q[1];

  // --------------------------------------------------------------
  // recovery timer and write protection
  // --------------------------------------------------------------
  logic [31:0] rec_cnt_q;

  // protection outlasts the supply event by the recovery delay
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rec_cnt_q <= 32'h0;
    else if (pf_s)
      rec_cnt_q <= RECOVERY_CYCLES[31:0];
    else if (rec_cnt_q != 32'h0)
      rec_cnt_q <= rec_cnt_q - 32'h1;
  end

  logic locked;
  assign locked = pf_s || (rec_cnt_q != 32'h0);
  assign write_protect = locked;

  // --------------------------------------------------------------
  // bus conditions, gated while locked
  // --------------------------------------------------------------
  logic start_cond;
  logic stop_cond;
  logic scl_rise;
  logic scl_fall;
  assign start_cond = !locked && scl_s && scl_q && sda_q && !sda_s;
  assign stop_cond  = !locked && scl_s && scl_q && !sda_q && sda_s;
  assign scl_rise   = !locked && scl_s && !scl_q;
  assign scl_fall   = !locked && !scl_s && scl_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      bus_busy <= 1'h0;
    else if (locked || stop_cond)
      bus_busy <= 1'h0;
    else if (start_cond)
      bus_busy <= 1'h1;
  end

  // --------------------------------------------------------------
  // register and ram storage
  // --------------------------------------------------------------
  data_byte_t ram_q [RAM_WORDS];
  data_byte_t rtc_q [`RTC_REGS];

  // decode of the timekeeping window, used for read and write
  function automatic logic is_rtc(input byte_addr_t a);
    return a >= `ADDR_SUBSEC;
  endfunction

  function automatic logic is_reserved(input byte_addr_t a);
    return a >= `ADDR_RSV_FIRST && a <= `ADDR_RSV_LAST;
  endfunction

  function automatic logic [3:0] rtc_index(input byte_addr_t a);
    byte_addr_t d;
    d = a - `ADDR_SUBSEC;
    return d[3:0];
  endfunction

  // --------------------------------------------------------------
  // protocol engine
  // --------------------------------------------------------------
  port_state_t state_q;
  logic [2:0]  bit_q;
  logic        ack_phase_q;
  data_byte_t  shift_q;
  data_byte_t  tx_q;
  logic        drive_low_q;
  logic        first_rd_q;
  logic        byte_full_q;
  logic        ack_ok_q;
  logic [6:0]  addr_hi_q;

  logic       wr_en;
  byte_addr_t wr_addr;
  data_byte_t wr_data;
  data_byte_t rd_data;

  always_comb
  begin
    if (is_rtc(addr_pointer))
      rd_data = rtc_q[rtc_index(addr_pointer)];
    else if (is_reserved(addr_pointer))
      rd_data = 8'h00;
    else
      rd_data = ram_q[addr_pointer];
  end

  data_byte_t rx_byte;
  assign rx_byte = {shift_q[6:0], sda_s};

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q      <= ST_IDLE;
      bit_q        <= 3'h0;
      ack_phase_q  <= 1'h0;
      shift_q      <= 8'h00;
      tx_q         <= 8'h00;
      drive_low_q  <= 1'h0;
      first_rd_q   <= 1'h0;
      byte_full_q  <= 1'h0;
      ack_ok_q     <= 1'h0;
      addr_hi_q    <= 7'h00;
      addr_pointer <= 15'h0000;
      wr_en        <= 1'h0;
      wr_addr      <= 15'h0000;
      wr_data      <= 8'h00;
    end
    else
    begin
      wr_en <= 1'h0;
      if (pf_s)
      begin
        state_q      <= ST_IDLE;
        drive_low_q  <= 1'h0;
        ack_phase_q  <= 1'h0;
        addr_pointer <= 15'h0000;
      end
      else if (stop_cond)
      begin
        state_q     <= ST_IDLE;
        drive_low_q <= 1'h0;
        ack_phase_q <= 1'h0;
      end
      else if (start_cond)
      begin
        state_q     <= ST_DEV_ADDR;
        bit_q       <= 3'h0;
        byte_full_q <= 1'h0;
        ack_phase_q <= 1'h0;
        drive_low_q <= 1'h0;
      end
      else if (scl_rise && state_q != ST_IDLE && state_q != ST_IGNORE)
      begin
        if (ack_phase_q)
        begin
          // ninth clock high: master answer on reads
          ack_ok_q <= !sda_s;
          if (state_q == ST_READ && !first_rd_q)
            addr_pointer <= addr_pointer + 15'h1;
        end
        else
        begin
          shift_q     <= rx_byte;
          bit_q       <= bit_q + 3'h1;
          byte_full_q <= (bit_q == `BIT_LAST);
        end
      end
      else if (scl_fall && state_q != ST_IDLE && state_q != ST_IGNORE)
      begin
        if (ack_phase_q)
        begin
          // end of ninth bit
          ack_phase_q <= 1'h0;
          drive_low_q <= 1'h0;
          if (state_q == ST_READ)
          begin
            // byte after the read address goes out with no master ack
            first_rd_q <= 1'h0;
            if (ack_ok_q || first_rd_q)
            begin
              tx_q        <= rd_data;
              drive_low_q <= !rd_data[7];
            end
            else
              state_q <= ST_IGNORE;
          end
        end
        else if (byte_full_q)
        begin
          // a full byte has arrived or been sent
          byte_full_q <= 1'h0;
          ack_phase_q <= 1'h1;
          drive_low_q <= 1'h0;
          case (state_q)
            ST_DEV_ADDR:
              if (shift_q[7:1] == `SLAVE_ADDR_7)
              begin
                drive_low_q <= 1'h1;
                first_rd_q  <= shift_q[0];
                state_q     <= shift_q[0] ? ST_READ : ST_ADDR_HI;
              end
              else
              begin
                ack_phase_q <= 1'h0;
                state_q     <= ST_IGNORE;
              end
            ST_ADDR_HI:
            begin
              addr_hi_q   <= shift_q[6:0];
              drive_low_q <= 1'h1;
              state_q     <= ST_ADDR_LO;
            end
            ST_ADDR_LO:
            begin
              addr_pointer <= {addr_hi_q, shift_q};
              drive_low_q  <= 1'h1;
              state_q      <= ST_WRITE;
            end
            ST_WRITE:
            begin
              wr_en       <= 1'h1;
              wr_addr     <= addr_pointer;
              wr_data     <= shift_q;
              drive_low_q <= 1'h1;
              addr_pointer <= addr_pointer + 15'h1;
            end
            ST_READ:
              drive_low_q <= 1'h0;
            default:
              state_q <= ST_IGNORE;
          endcase
        end
        else if (state_q == ST_READ)
          drive_low_q <= !tx_q[`BIT_LAST - bit_q];
        else
          drive_low_q <= 1'h0;
      end
    end
  end

  // --------------------------------------------------------------
  // storage writes, blocked while protected
  // --------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (wr_en && !locked && !is_rtc(wr_addr) && !is_reserved(wr_addr))
      ram_q[wr_addr] <= wr_data;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      for (int i = 0; i < `RTC_REGS; i++)
        rtc_q[i] <= 8'h00;
    else if (wr_en && !locked && is_rtc(wr_addr))
      rtc_q[rtc_index(wr_addr)] <= wr_data;
  end

  // --------------------------------------------------------------
  // open-drain pin
  // --------------------------------------------------------------
  assign sda_out = 1'h0;
  assign sda_oe  = drive_low_q && !locked;
endmodule

// *** tb/bus_master_model.sv ***
// two-wire bus master: start, stop and byte tasks
// assumes the bench makes the pulled-up data line
`timescale 1ns/100ps
module bus_master_model
(
  // clock
  input  wire logic clk,
  // bus
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_pull
);
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // 6 clk low, 2 high: long low leaves room for the slave reply
  task automatic bit_io(input logic b, output logic s);
    sda_pull <= !b;
    cyc(3);
    scl <= 1'b1;
    cyc(1);
    s = sda_line;
    cyc(1);
    scl <= 1'b0;
    cyc(3);
  endtask
  task automatic start_cond();
    sda_pull <= 1'b0;
    cyc(3);
    scl <= 1'b1;
    cyc(4);
    sda_pull <= 1'b1;
    cyc(4);
    scl <= 1'b0;
    cyc(3);
  endtask
  task automatic stop_cond();
    sda_pull <= 1'b1;
    cyc(3);
    scl <= 1'b1;
    cyc(4);
    sda_pull <= 1'b0;
    cyc(6);
  endtask
  // a9 is our ninth bit: 1 leaves the line to the slave, 0 acks
  task automatic xfer(input logic [7:0] tx, input logic a9,
                      output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(a9, ack);
  endtask
endmodule

// *** tb/rtc_sram_serial_slave_port_bench.sv ***
// self-checking bench for the serial slave port
// assumes the master model and the bound checker
`timescale 1ns/100ps
module rtc_sram_serial_slave_port_bench;
  import serial_port_pkg::*;
  localparam int REC = 20;
  logic       clk;
  logic       reset;
  logic       power_fail;
  logic       scl;
  logic       sda_pull;
  logic       sda_out;
  logic       sda_oe;
  logic       write_protect;
  logic       bus_busy;
  byte_addr_t addr_pointer;
  wire logic  sda_line;
  logic [7:0] rx;
  logic       ack;
  int         errors;
  int         num_checks;
  int         cycles;
  assign sda_line = !sda_pull && !(sda_oe && !sda_out);
  rtc_sram_serial_slave_port #(.RECOVERY_CYCLES(REC)) DUT (.clk(clk),
    .reset(reset), .power_fail(power_fail), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .write_protect(write_protect), .bus_busy(bus_busy),
    .addr_pointer(addr_pointer));
  bus_master_model m (.clk(clk), .sda_line(sda_line), .scl(scl),
    .sda_pull(sda_pull));
  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic [7:0] b);
    m.xfer(b, 1'b1, rx, ack);
    chk("ack", {15'h0000, ack}, 16'h0000);
  endtask
  task automatic set_ptr(input logic [15:0] a);
    m.start_cond();
    wb(8'hD0);
    wb(a[15:8]);
    wb(a[7:0]);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      final_report();
    end
  end
  initial
  begin
    errors = 0;
    num_checks = 0;
    cycles = 0;
    reset = 1'b1;
    power_fail = 1'b0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (REC + 10) @(posedge clk);
    set_ptr(16'hFFEE);
    chk("ptr", {1'b0, addr_pointer}, 16'h7FEE);
    wb(8'hAA);
    wb(8'h55);
    chk("ptr", {1'b0, addr_pointer}, 16'h7FF0);
    chk("busy", {15'h0000, bus_busy}, 16'h0001);
    m.stop_cond();
    chk("busy", {15'h0000, bus_busy}, 16'h0000);
    set_ptr(16'h7FFF);
    wb(8'h33);
    chk("ptr", {1'b0, addr_pointer}, 16'h0000);
    set_ptr(16'h7FF8);
    wb(8'h5A);
    wb(8'h12);
    set_ptr(16'h7FF8);
    m.start_cond();
    wb(8'hD1);
    chk("ptr", {1'b0, addr_pointer}, 16'h7FF8);
    m.xfer(8'hFF, 1'b0, rx, ack);
    chk("ctrl", {8'h00, rx}, 16'h005A);
    m.xfer(8'hFF, 1'b1, rx, ack);
    chk("seconds", {8'h00, rx}, 16'h0012);
    chk("nack", {15'h0000, ack}, 16'h0001);
    m.stop_cond();
    m.start_cond();
    m.xfer(8'hA0, 1'b1, rx, ack);
    chk("ack", {15'h0000, ack}, 16'h0001);
    m.stop_cond();
    set_ptr(16'h7FEF);
    m.start_cond();
    wb(8'hD1);
    m.xfer(8'hFF, 1'b0, rx, ack);
    chk("ram", {8'h00, rx}, 16'h0055);
    m.xfer(8'hFF, 1'b1, rx, ack);
    chk("reserved", {8'h00, rx}, 16'h0000);
    m.stop_cond();
    m.start_cond();
    wb(8'hD1);
    chk("ptr", {1'b0, addr_pointer}, 16'h7FF1);
    m.xfer(8'hFF, 1'b1, rx, ack);
    chk("reserved", {8'h00, rx}, 16'h0000);
    m.stop_cond();
    set_ptr(16'h0123);
    power_fail <= 1'b1;
    m.cyc(6);
    chk("ptr", {1'b0, addr_pointer}, 16'h0000);
    m.stop_cond();
    m.start_cond();
    m.xfer(8'hD0, 1'b1, rx, ack);
    chk("ack", {15'h0000, ack}, 16'h0001);
    m.stop_cond();
    power_fail <= 1'b0;
    m.cyc(REC - 4);
    chk("wp", {15'h0000, write_protect}, 16'h0001);
    m.cyc(12);
    chk("wp", {15'h0000, write_protect}, 16'h0000);
    final_report();
  end
endmodule

// *** tb/rtc_sram_serial_slave_port_checker.sv ***
// pin and status checks for the serial slave port
// assumes bind onto the port module, RECOVERY_CYCLES handed on
`timescale 1ns/100ps
module port_checker
#(
  parameter int RECOVERY_CYCLES = 20
)
(
  // clock and reset
  input wire logic         clk,
  input wire logic         reset,
  // supply and bus
  input wire logic         power_fail,
  input wire logic         scl_in,
  input wire logic         sda_in,
  input wire logic         sda_out,
  input wire logic         sda_oe,
  // status
  input wire logic         write_protect,
  input wire logic         bus_busy,
  input serial_port_pkg::byte_addr_t addr_pointer
);
  import serial_port_pkg::*;
  logic [15:0] good_q;
  // cycles of good supply, saturating so it never wraps back
  always_ff @(posedge clk or posedge reset)
    if (reset)
      good_q <= 16'h0000;
    else if (power_fail)
      good_q <= 16'h0000;
    else if (good_q != 16'hFFFF)
      good_q <= good_q + 16'h0001;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_pull_only;
    sda_oe |-> !sda_out;
  endproperty
  a_pull_only: assert property (p_pull_only)
    else $error("data line driven high");
  // protect edges are excluded: the gate may drop oe at any time
  property p_oe_stable;
    ($changed(sda_oe) && !write_protect && !$past(write_protect))
      |-> !scl_in;
  endproperty
  a_oe_stable: assert property (p_oe_stable)
    else $error("data changed while clock high");
  property p_start_busy;
    (scl_in && $fell(sda_in) && !write_protect) |-> ##[1:6] bus_busy;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("start not seen");
  property p_stop_idle;
    (scl_in && $rose(sda_in)) |-> ##[1:6] !bus_busy;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("stop not seen");
  property p_fail_ptr;
    $rose(power_fail) |-> ##[1:5] (addr_pointer == 15'h0000);
  endproperty
  a_fail_ptr: assert property (p_fail_ptr)
    else $error("pointer kept on power fail");
  property p_fail_wp;
    power_fail |-> ##[1:4] write_protect;
  endproperty
  a_fail_wp: assert property (p_fail_wp)
    else $error("no protect on power fail");
  property p_quiet;
    (write_protect && $past(write_protect)) |-> !sda_oe;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("bus driven while protected");
  property p_recover;
    $fell(write_protect) |-> (good_q >= RECOVERY_CYCLES);
  endproperty
  a_recover: assert property (p_recover)
    else $error("protect released early");
endmodule

bind rtc_sram_serial_slave_port port_checker
  #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) u_chk (.clk(clk), .reset(reset),
  .power_fail(power_fail), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .write_protect(write_protect),
  .bus_busy(bus_busy), .addr_pointer(addr_pointer));
